// ==== rtl/hma_params.svh ====
// Register offsets, control fields and reset values of the multiply unit
`ifndef HMA_PARAMS_SVH
`define HMA_PARAMS_SVH

// Byte offsets of the word registers
`define HMA_OFF_CTRL 6'h00
`define HMA_OFF_OPA 6'h04
`define HMA_OFF_OPB 6'h08
`define HMA_OFF_ACC0 6'h0C
`define HMA_OFF_ACC1 6'h10
`define HMA_OFF_ACC2 6'h14
`define HMA_OFF_STAT 6'h18
`define HMA_OFF_MASK 6'h1C

// Fields of the 8-bit multiplier_control register
`define HMA_CTL_SIGNED 0
`define HMA_CTL_MAC 1
`define HMA_CTL_SUB 2
`define HMA_CTL_ONEOP 3
`define HMA_CTL_SQUARE 4
`define HMA_CTL_CLEAR 5
`define HMA_CTL_ACCWR 6
`define HMA_CTL_OVF 7

// Event bits of the status and mask registers
`define HMA_EV_DONE 0
`define HMA_EV_OVF 1
`define HMA_EV_W 2

// Reset values
`define HMA_CTRL_RST 8'h00
`define HMA_DATA_RST 16'h0000
`define HMA_ACC_RST 48'h000000000000
`define HMA_MASK_RST 2'h0

`endif

// ==== rtl/hma_pkg.sv ====
// Types shared by the multiply unit files
package hma_pkg;

    // Operation decoded from the control register, one-hot
    typedef enum logic [3:0] {
        HMA_OP_MUL = 4'b0001,
        HMA_OP_MAC = 4'b0010,
        HMA_OP_SUB = 4'b0100,
        HMA_OP_NEG = 4'b1000
    } hma_op_t;

    // Accumulator width and operand width
    typedef logic [47:0] hma_acc_t;
    typedef logic [15:0] hma_word_t;

endpackage : hma_pkg

// ==== rtl/hma_mul.sv ====
// Combinational 16x16 signed or unsigned multiplier core
`timescale 1ns/1ps
module hma_mul (
    input wire logic [15:0] a_i,
    input wire logic [15:0] b_i,
    input wire logic signed_i,
    output logic [32:0] prod_o
);
    logic signed [16:0] a_ext;
    logic signed [16:0] b_ext;
    logic signed [33:0] full;

    // Extend each operand by one bit so both kinds share a signed product
    always_comb begin
        a_ext = {signed_i & a_i[15], a_i};
        b_ext = {signed_i & b_i[15], b_i};
        full = a_ext * b_ext;
        prod_o = full[32:0];
    end
endmodule : hma_mul

// ==== rtl/hma_irq.sv ====
// Sticky event flags with write-one-to-clear, mask and interrupt line
`timescale 1ns/1ps
module hma_irq #(
    parameter int W = 2
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [W-1:0] set_i,
    input wire logic stat_we_i,
    input wire logic mask_we_i,
    input wire logic [W-1:0] wdata_i,
    output logic [W-1:0] stat_o,
    output logic [W-1:0] mask_o,
    output logic irq_o
);
    logic [W-1:0] stat_r;
    logic [W-1:0] stat_nxt;
    logic [W-1:0] mask_r;
    logic [W-1:0] mask_nxt;

    // Set beats a clear that lands in the same cycle
    always_comb begin
        stat_nxt = stat_r;
        if (stat_we_i) begin
            stat_nxt = stat_r & ~wdata_i;
        end
        stat_nxt = stat_nxt | set_i;
        mask_nxt = mask_we_i ? wdata_i : mask_r;
    end

    // Flag and mask registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            stat_r <= '0;
            mask_r <= '0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign stat_o = stat_r;
    assign mask_o = mask_r;
    assign irq_o = |(stat_r & mask_r);
endmodule : hma_irq

// ==== rtl/hma_top.sv ====
// Hardware multiply-accumulate unit with AHB-Lite register access
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "hma_params.svh"
module hma_top (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic irq_o
);
    // Bus address-phase capture
    logic wr_pend_r;
    logic wr_pend_nxt;
    logic [5:0] wr_addr_r;
    logic [5:0] wr_addr_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    logic addr_take;

    // Programmer-visible state and the operand load flags
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    hma_pkg::hma_word_t opa_r;
    hma_pkg::hma_word_t opa_nxt;
    hma_pkg::hma_word_t opb_r;
    hma_pkg::hma_word_t opb_nxt;
    hma_pkg::hma_acc_t acc_r;
    hma_pkg::hma_acc_t acc_nxt;
    logic a_ld_r;
    logic a_ld_nxt;
    logic b_ld_r;
    logic b_ld_nxt;

    // Datapath signals
    hma_pkg::hma_op_t op;
    logic sgn;
    logic start;
    logic ovf_ev;
    logic wr_ctrl;
    logic wr_opa;
    logic wr_opb;
    logic wr_stat;
    logic wr_mask;
    logic [15:0] mul_a;
    logic [15:0] mul_b;
    logic [32:0] prod;
    logic [48:0] prod_x;
    logic [48:0] acc_x;
    logic [48:0] res_x;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [1:0] ev_set;
    logic [1:0] stat_view;
    logic wr_acc0;
    logic wr_acc1;
    logic wr_acc2;
    logic sq_mode;
    logic one_op;
    logic clr_req;

    // Address phase taken when selected, active and bus ready
    assign addr_take = hsel_i & htrans_i[1] & hready_i;

    // Latch a write for its data phase
    always_comb begin
        wr_pend_nxt = addr_take & hwrite_i;
        wr_addr_nxt = addr_take ? haddr_i[5:0] : wr_addr_r;
    end

    // Bus capture registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 6'h00;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
        end
    end

    // Write strobes in the data phase
    always_comb begin
        wr_ctrl = wr_pend_r && (wr_addr_r == `HMA_OFF_CTRL);
        wr_opa = wr_pend_r && (wr_addr_r == `HMA_OFF_OPA);
        wr_opb = wr_pend_r && (wr_addr_r == `HMA_OFF_OPB);
        wr_stat = wr_pend_r && (wr_addr_r == `HMA_OFF_STAT);
        wr_mask = wr_pend_r && (wr_addr_r == `HMA_OFF_MASK);
        wr_acc0 = wr_pend_r && (wr_addr_r == `HMA_OFF_ACC0);
        wr_acc1 = wr_pend_r && (wr_addr_r == `HMA_OFF_ACC1);
        wr_acc2 = wr_pend_r && (wr_addr_r == `HMA_OFF_ACC2);
    end

    // Operand modes and the clear request, named once
    always_comb begin
        sq_mode = ctrl_r[`HMA_CTL_SQUARE];
        one_op = ctrl_r[`HMA_CTL_ONEOP];
        clr_req = wr_ctrl && hwdata_i[`HMA_CTL_CLEAR];
    end

    // Decode the operation from the control bits
    always_comb begin
        sgn = ctrl_r[`HMA_CTL_SIGNED];
        op = hma_pkg::HMA_OP_MUL;
        if (ctrl_r[`HMA_CTL_MAC] && ctrl_r[`HMA_CTL_SUB]) begin
            // Both set: negate when signed, plain multiply otherwise
            op = sgn ? hma_pkg::HMA_OP_NEG : hma_pkg::HMA_OP_MUL;
        end else if (ctrl_r[`HMA_CTL_MAC]) begin
            op = hma_pkg::HMA_OP_MAC;
        end else if (ctrl_r[`HMA_CTL_SUB]) begin
            op = hma_pkg::HMA_OP_SUB;
        end
    end

    // Operand loading and automatic start
    always_comb begin
        opa_nxt = opa_r;
        opb_nxt = opb_r;
        a_ld_nxt = a_ld_r;
        b_ld_nxt = b_ld_r;
        start = 1'b0;
        if (wr_opa) begin
            opa_nxt = hwdata_i[15:0];
            a_ld_nxt = 1'b1;
            // Square starts on the single operand; else wait for B
            if (sq_mode || (!one_op && b_ld_r)) begin
                start = 1'b1;
            end
        end
        if (wr_opb) begin
            opb_nxt = hwdata_i[15:0];
            b_ld_nxt = 1'b1;
            // One-operand mode reuses the held A value
            if (!sq_mode && (one_op || a_ld_r)) begin
                start = 1'b1;
            end
        end
        if (start) begin
            a_ld_nxt = 1'b0;
            b_ld_nxt = 1'b0;
        end
        if (clr_req) begin
            opa_nxt = `HMA_DATA_RST;
            opb_nxt = `HMA_DATA_RST;
            a_ld_nxt = 1'b0;
            b_ld_nxt = 1'b0;
        end
    end

    // Multiplier inputs follow the value being written this cycle
    always_comb begin
        mul_a = opa_nxt;
        mul_b = sq_mode ? opa_nxt : opb_nxt;
    end

    // Single-cycle product
    hma_mul u_mul (
        .a_i(mul_a),
        .b_i(mul_b),
        .signed_i(sgn),
        .prod_o(prod)
    );

    // 49-bit arithmetic so overflow of the 48-bit sum is visible
    always_comb begin
        prod_x = {{16{prod[32]}}, prod};
        acc_x = {sgn & acc_r[47], acc_r};
        unique case (op)
            hma_pkg::HMA_OP_MAC: res_x = acc_x + prod_x;
            hma_pkg::HMA_OP_SUB: res_x = acc_x - prod_x;
            hma_pkg::HMA_OP_NEG: res_x = 49'h0 - prod_x;
            default: res_x = prod_x;
        endcase
    end

    // Overflow only for accumulate and subtract results
    always_comb begin
        ovf_ev = 1'b0;
        if (start && (op == hma_pkg::HMA_OP_MAC ||
                      op == hma_pkg::HMA_OP_SUB)) begin
            // Signed: sign bits disagree; unsigned: carry or borrow out
            ovf_ev = sgn ? (res_x[48] ^ res_x[47]) : res_x[48];
        end
    end

    // Accumulator update: result wins, then software word writes
    always_comb begin
        acc_nxt = acc_r;
        if (start) begin
            acc_nxt = res_x[47:0];
        end else if (ctrl_r[`HMA_CTL_ACCWR]) begin
            if (wr_acc0) begin
                acc_nxt[15:0] = hwdata_i[15:0];
            end
            if (wr_acc1) begin
                acc_nxt[31:16] = hwdata_i[15:0];
            end
            if (wr_acc2) begin
                acc_nxt[47:32] = hwdata_i[15:0];
            end
        end
        if (clr_req) begin
            acc_nxt = `HMA_ACC_RST;
        end
    end

    // Control register; clear bit self-clears, overflow is sticky
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt[6:0] = hwdata_i[6:0];
            ctrl_nxt[`HMA_CTL_CLEAR] = 1'b0;
            // Writing zero clears overflow; writing one leaves it
            ctrl_nxt[`HMA_CTL_OVF] = ctrl_r[`HMA_CTL_OVF] &
                                     hwdata_i[`HMA_CTL_OVF];
        end
        if (ovf_ev) begin
            ctrl_nxt[`HMA_CTL_OVF] = 1'b1;
        end
    end

    // Control register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_r <= `HMA_CTRL_RST;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Operand registers and their load flags
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            opa_r <= `HMA_DATA_RST;
            opb_r <= `HMA_DATA_RST;
            a_ld_r <= 1'b0;
            b_ld_r <= 1'b0;
        end else begin
            opa_r <= opa_nxt;
            opb_r <= opb_nxt;
            a_ld_r <= a_ld_nxt;
            b_ld_r <= b_ld_nxt;
        end
    end

    // Accumulator register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_r <= `HMA_ACC_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // Completion and overflow events
    always_comb begin
        ev_set = 2'h0;
        ev_set[`HMA_EV_DONE] = start;
        ev_set[`HMA_EV_OVF] = ovf_ev;
    end

    // Sticky status, mask and interrupt line
    hma_irq #(
        .W(`HMA_EV_W)
    ) u_irq (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .set_i(ev_set),
        .stat_we_i(wr_stat),
        .mask_we_i(wr_mask),
        .wdata_i(hwdata_i[1:0]),
        .stat_o(stat),
        .mask_o(mask),
        .irq_o(irq_o)
    );

    // Status as it stands after this cycle; a set beats a clear
    always_comb begin
        stat_view = stat;
        if (wr_stat) begin
            stat_view = stat & ~hwdata_i[1:0];
        end
        stat_view = stat_view | ev_set;
    end

    // Read mux from next values so a write is seen by the next read
    always_comb begin
        hrdata_nxt = hrdata_r;
        if (addr_take && !hwrite_i) begin
            unique case (haddr_i[5:0])
                `HMA_OFF_CTRL: hrdata_nxt = {24'h000000, ctrl_nxt};
                `HMA_OFF_OPA: hrdata_nxt = {16'h0000, opa_nxt};
                `HMA_OFF_OPB: hrdata_nxt = {16'h0000, opb_nxt};
                `HMA_OFF_ACC0: hrdata_nxt = {16'h0000, acc_nxt[15:0]};
                `HMA_OFF_ACC1: hrdata_nxt = {16'h0000, acc_nxt[31:16]};
                `HMA_OFF_ACC2: hrdata_nxt = {16'h0000, acc_nxt[47:32]};
                `HMA_OFF_STAT: hrdata_nxt = {30'h0, stat_view};
                `HMA_OFF_MASK: hrdata_nxt = {30'h0,
                                             wr_mask ? hwdata_i[1:0] : mask};
                default: hrdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hrdata_r <= 32'h00000000;
        end else begin
            hrdata_r <= hrdata_nxt;
        end
    end

    // Zero-wait slave, always OKAY
    assign hrdata_o = hrdata_r;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Size is always a word here
    logic unused_size;
    assign unused_size = ^hsize_i;
endmodule : hma_top

// ==== tb/hma_top_assertions.sv ====
// Bus-side checks of the multiply-accumulate unit
`timescale 1ns/1ps
module hma_top_assertions (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic irq_o
);
    logic ap;
    logic rd_ap;
    logic wr_dp_r;
    logic wr_dp_nxt;

    // Address phases taken, and write data phases
    assign ap = hsel_i & htrans_i[1] & hready_i;
    assign rd_ap = ap & ~hwrite_i;
    always_comb wr_dp_nxt = rst_i ? 1'b0 : (ap & hwrite_i);
    always_ff @(posedge clk_sys_i) wr_dp_r <= wr_dp_nxt;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // Clear written, then accumulator low word read back
    sequence s_clear_then_read;
        ap && hwrite_i && haddr_i[5:0] == 6'h00 ##1 hwdata_i[5]
            ##1 rd_ap && haddr_i[5:0] == 6'h0C;
    endsequence

    AST_READY: assert property (hreadyout_o)
        else $error("wait state inserted");
    AST_OKAY: assert property (!hresp_o)
        else $error("error response given");
    AST_CTRL_WIDTH: assert property (rd_ap && haddr_i[5:0] == 6'h00
        |=> hrdata_o[31:8] == 24'h0) else $error("control wider than 8");
    AST_DATA_WIDTH: assert property (rd_ap |=> hrdata_o[31:16] == 16'h0)
        else $error("data wider than 16");
    AST_UNMAPPED: assert property (rd_ap && haddr_i[5] |=> hrdata_o == 0)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (!rd_ap |=> $stable(hrdata_o))
        else $error("read data moved without a read");
    AST_IRQ_CAUSE: assert property ($changed(irq_o) |-> $past(wr_dp_r))
        else $error("interrupt moved without a write");
    AST_CLEAR: assert property (s_clear_then_read |=> hrdata_o == 0)
        else $error("accumulator not cleared");
endmodule : hma_top_assertions

// ==== tb/hma_cpu_model.sv ====
// Processor-side master making single-word AHB-Lite transfers
`timescale 1ns/1ps
module hma_cpu_model (
    input wire logic clk_sys_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    // Idle bus at time zero
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end

    // Address phase, then data phase, each held until hready
    task automatic xfer(input logic w, input logic [5:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel_o <= 1'b1;
        htrans_o <= 2'h2;
        haddr_o <= {26'h0, a};
        hwrite_o <= w;
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= d;
        do @(posedge clk_sys_i); while (hready_i !== 1'b1);
        q = hrdata_i;
        hwdata_o <= ~d; // Released data no longer holds
    endtask : xfer
endmodule : hma_cpu_model

// ==== tb/hma_top_test.sv ====
// Register-level test of the multiply-accumulate unit
`timescale 1ns/1ps
`include "hma_params.svh"
module hma_top_test;
    localparam logic [15:0] OPA = 16'hFFFE;
    localparam logic [7:0] OPS [7] = '{8'h00, 8'h02, 8'h04, 8'h01, 8'h07,
        8'h03, 8'h05};
    logic clk_sys_i;
    logic rst_i;
    logic hsel;
    logic hwrite;
    logic hready;
    logic hresp;
    logic irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    int mismatches;
    int samples_checked;

    hma_top u_hma_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .irq_o(irq));
    hma_cpu_model u_hma_cpu_model (.clk_sys_i(clk_sys_i), .hready_i(hready),
        .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    // Free-running system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] want);
        samples_checked++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [31:0] q;
        u_hma_cpu_model.xfer(1'b1, a, {16'h0, d}, q);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [47:0] want);
        logic [31:0] q;
        u_hma_cpu_model.xfer(1'b0, a, 32'h0, q);
        check({16'h0, q}, want);
    endtask : rd

    task automatic acc_is(input logic [47:0] e);
        rd(`HMA_OFF_ACC0, {32'h0, e[15:0]});
        rd(`HMA_OFF_ACC1, {32'h0, e[31:16]});
        rd(`HMA_OFF_ACC2, {32'h0, e[47:32]});
    endtask : acc_is

    task automatic irq_is(input logic v);
        #1;
        check({47'h0, irq}, {47'h0, v});
    endtask : irq_is

    // Accumulator after two identical operations from zero
    function automatic logic [47:0] expect_acc(input logic [7:0] c);
        longint p;
        p = c[0] ? longint'($signed(OPA)) * 3 : longint'(OPA) * 3;
        if (c[0] && c[2:1] == 2'h3) return 48'(-p);
        if (c[1]) return 48'(2 * p);
        if (c[2]) return 48'(-2 * p);
        return 48'(p);
    endfunction : expect_acc

    task automatic wrap_up;
        $display("mismatches %0d samples_checked %0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // Main sequence of register accesses
    initial begin
        rst_i = 1'b1;
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(`HMA_OFF_CTRL, 48'h0);
        acc_is(48'h0);
        for (int i = 0; i < 7; i++) begin
            wr(`HMA_OFF_CTRL, {8'h0, OPS[i] | 8'h20});
            repeat (2) begin
                wr(`HMA_OFF_OPA, OPA);
                wr(`HMA_OFF_OPB, 16'h0003);
            end
            acc_is(expect_acc(OPS[i]));
            if (OPS[i] == 8'h07) begin
                rd(`HMA_OFF_ACC0, 48'h0006);
            end
        end
        wr(`HMA_OFF_CTRL, 16'h0020);
        rd(`HMA_OFF_ACC0, 48'h0);
        wr(`HMA_OFF_STAT, 16'h0003);
        rd(`HMA_OFF_STAT, 48'h0);
        wr(`HMA_OFF_CTRL, 16'h0004);
        wr(`HMA_OFF_OPA, 16'h0002);
        wr(`HMA_OFF_OPB, 16'h0003);
        rd(`HMA_OFF_ACC0, 48'hFFFA);
        rd(`HMA_OFF_CTRL, 48'h84);
        rd(`HMA_OFF_STAT, 48'h3);
        irq_is(1'b0);
        wr(`HMA_OFF_MASK, 16'h0002);
        irq_is(1'b1);
        wr(`HMA_OFF_STAT, 16'h0002);
        irq_is(1'b0);
        rd(`HMA_OFF_STAT, 48'h1);
        wr(`HMA_OFF_CTRL, 16'h0030);
        wr(`HMA_OFF_OPA, 16'h0005);
        rd(`HMA_OFF_ACC0, 48'h19);
        wr(`HMA_OFF_OPB, 16'h0002);
        rd(`HMA_OFF_ACC0, 48'h19);
        wr(`HMA_OFF_CTRL, 16'h0028);
        wr(`HMA_OFF_OPA, 16'h0003);
        wr(`HMA_OFF_OPB, 16'h0004);
        wr(`HMA_OFF_OPB, 16'h0005);
        rd(`HMA_OFF_ACC0, 48'hF);
        wr(`HMA_OFF_CTRL, 16'h0040);
        wr(`HMA_OFF_ACC0, 16'h1234);
        wr(`HMA_OFF_CTRL, 16'h0000);
        wr(`HMA_OFF_ACC0, 16'h5555);
        rd(`HMA_OFF_ACC0, 48'h1234);
        wr(6'h20, 16'hFFFF);
        rd(6'h20, 48'h0);
        wrap_up();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        mismatches++;
        wrap_up();
    end
endmodule : hma_top_test

bind hma_top hma_top_assertions u_hma_top_assertions (.*);
